// ==== core/led_level_regs.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "led_level_params.svh"

module led_level_regs
#(
  parameter int CHANNELS = `CHANNEL_COUNT
)
(
  input logic clk_in,
  input logic arst_n_in,
  input led_level_pkg::apb_req_t apb_req_in,
  output led_level_pkg::apb_rsp_t apb_rsp_out,
  input led_level_pkg::channel_pins_t pins_in,
  output logic [3:0] status_led_out,
  output logic [3:0] fault_led_out,
  output logic fault_out,
  output logic global_supply_error_out,
  output logic irq_out
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // The register layout packs exactly four channels per nibble
  generate
    if (CHANNELS != `CHANNEL_COUNT)
    begin : g_chk
      $error("led_level_regs serves exactly four channels");
    end
  endgenerate

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [7:0] ADDR_LED = 8'(`IDX_LED_CONTROL << `ADDR_SHIFT);
  localparam logic [7:0] ADDR_LEVEL = 8'(`IDX_LEVEL_FAULTS << `ADDR_SHIFT);
  localparam logic [7:0] ADDR_CONFIG = 8'(`IDX_CONFIG << `ADDR_SHIFT);
  localparam logic [7:0] ADDR_ISTAT = 8'(`IDX_IRQ_STATUS << `ADDR_SHIFT);
  localparam logic [7:0] ADDR_ICLR = 8'(`IDX_IRQ_CLEAR << `ADDR_SHIFT);
  localparam logic [7:0] ADDR_IEN = 8'(`IDX_IRQ_ENABLE << `ADDR_SHIFT);
  localparam logic [7:0] ADDR_PINS = 8'(`IDX_PIN_STATE << `ADDR_SHIFT);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  led_level_pkg::channel_pins_t pins_sync;
  logic [3:0] level_sync;
  logic [3:0] demag_sync;
  logic [3:0] ok_low_sync;
  logic [3:0] ok_high_sync;

  sync_2ff #(.WIDTH($bits(led_level_pkg::channel_pins_t))) u_sync
  (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .d_in(pins_in),
    .q_out(pins_sync)
  );

  assign level_sync = pins_sync.io_channel_pin;
  assign demag_sync = pins_sync.demag_thermal;
  assign ok_low_sync = pins_sync.supply_ok_low;
  assign ok_high_sync = pins_sync.supply_ok_high;
  // Sync output reads zero, i.e. supply bad, until two edges after reset
  logic [1:0] primed_reg;
  logic sync_valid;
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      primed_reg <= '0;
    else
      primed_reg <= {primed_reg[0], 1'b1};
  end
  assign sync_valid = primed_reg[1];

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic setup_phase;
  logic access_phase;
  logic hit_led;
  logic hit_level;
  logic hit_config;
  logic hit_istat;
  logic hit_iclr;
  logic hit_ien;
  logic hit_pins;
  logic hit_any;
  logic write_ok;
  logic wr_led;
  logic wr_config;
  logic wr_iclr;
  logic wr_ien;
  logic rd_level;

  assign setup_phase = apb_req_in.psel & ~apb_req_in.penable;
  assign access_phase = apb_req_in.psel & apb_req_in.penable;
  assign hit_led = apb_req_in.paddr == ADDR_LED;
  assign hit_level = apb_req_in.paddr == ADDR_LEVEL;
  assign hit_config = apb_req_in.paddr == ADDR_CONFIG;
  assign hit_istat = apb_req_in.paddr == ADDR_ISTAT;
  assign hit_iclr = apb_req_in.paddr == ADDR_ICLR;
  assign hit_ien = apb_req_in.paddr == ADDR_IEN;
  assign hit_pins = apb_req_in.paddr == ADDR_PINS;
  assign hit_any = hit_led | hit_level | hit_config | hit_istat
                 | hit_iclr | hit_ien | hit_pins;
  // Writes to read-only words are refused with an error
  assign write_ok = hit_led | hit_config | hit_iclr | hit_ien;
  assign wr_led = access_phase & apb_req_in.pwrite & hit_led;
  assign wr_config = access_phase & apb_req_in.pwrite & hit_config;
  assign wr_iclr = access_phase & apb_req_in.pwrite & hit_iclr;
  assign wr_ien = access_phase & apb_req_in.pwrite & hit_ien;
  assign rd_level = access_phase & ~apb_req_in.pwrite & hit_level;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] led_reg;
  led_level_pkg::config_t config_reg;
  logic [3:0] demag_reg;
  logic [3:0] demag_next;
  logic [3:0] supply_reg;
  logic [3:0] supply_next;
  logic [3:0] supply_bad;
  logic [7:0] snap_reg;
  logic [3:0] clr_demag;
  logic [3:0] clr_supply;
  logic [`IRQ_MSB:0] irq_status_reg;
  logic [`IRQ_MSB:0] irq_status_next;
  logic [`IRQ_MSB:0] irq_enable_reg;
  logic [`IRQ_MSB:0] irq_set;
  logic [`IRQ_MSB:0] irq_clr;
  logic [31:0] prdata_reg;
  logic [7:0] level_view;
  logic [7:0] rd_byte;
  logic [3:0] status_led_reg;
  logic [3:0] fault_led_reg;
  logic fault_pin_reg;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      led_reg <= `LED_CONTROL_RESET;
    else if (wr_led)
      led_reg <= apb_req_in.pwdata[7:0];
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      config_reg <= `CONFIG_RESET;
    else if (wr_config)
      config_reg <= apb_req_in.pwdata[`CONFIG_MSB:0];
  end

  // ****************************************************************
  // Per-channel fault latches
  // ****************************************************************
  // Only bits that were in the read snapshot are cleared, so a fault
  // raised after the setup cycle survives the read; set also wins.
  assign clr_demag = rd_level ? snap_reg[7:4] : 4'h0;
  assign clr_supply = rd_level ? snap_reg[3:0] : 4'h0;

  generate
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_chan
      assign supply_bad[i] = sync_valid & (config_reg.supply_on_threshold_sel
                           ? ~ok_high_sync[i] : ~ok_low_sync[i]);
      assign demag_next[i] = demag_sync[i]
                           | (demag_reg[i] & ~clr_demag[i]);
      assign supply_next[i] = supply_bad[i]
                            | (supply_reg[i] & ~clr_supply[i]);
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      demag_reg <= `LEVEL_FAULTS_RESET;
      supply_reg <= `LEVEL_FAULTS_RESET;
    end
    else
    begin
      demag_reg <= demag_next;
      supply_reg <= supply_next;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  assign irq_set[`IRQ_SUPPLY_BIT] = (|supply_reg)
                                  & ~config_reg.supply_summary_disable;
  assign irq_set[`IRQ_DEMAG_BIT] = |demag_reg;
  assign irq_clr = wr_iclr ? apb_req_in.pwdata[`IRQ_MSB:0] : `IRQ_RESET;
  assign irq_status_next = irq_set | (irq_status_reg & ~irq_clr);

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_status_reg <= `IRQ_RESET;
      irq_enable_reg <= `IRQ_RESET;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (wr_ien)
        irq_enable_reg <= apb_req_in.pwdata[`IRQ_MSB:0];
    end
  end

  assign irq_out = |(irq_status_reg & irq_enable_reg);
  assign global_supply_error_out = irq_status_reg[`IRQ_SUPPLY_BIT];

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign level_view = {demag_reg, config_reg.level_or_supply_select
                       ? supply_reg : level_sync};
  assign rd_byte = hit_led ? led_reg
                 : hit_level ? level_view
                 : hit_config ? {2'h0, config_reg}
                 : hit_istat ? {6'h00, irq_status_reg}
                 : hit_ien ? {6'h00, irq_enable_reg}
                 : hit_pins ? {ok_high_sync, ok_low_sync}
                 : 8'h00;

  // Read data is sampled in the setup cycle and held for the access
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prdata_reg <= 32'h0000_0000;
      snap_reg <= 8'h00;
    end
    else if (setup_phase)
    begin
      prdata_reg <= {24'h00_0000, rd_byte};
      snap_reg <= {demag_reg, supply_reg};
    end
  end

  assign apb_rsp_out.prdata = prdata_reg;
  assign apb_rsp_out.pready = access_phase;
  assign apb_rsp_out.pslverr = access_phase
                             & (~hit_any | (apb_req_in.pwrite & ~write_ok));

  // ****************************************************************
  // LED and fault pin drivers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      status_led_reg <= `LED_OUT_RESET;
      fault_led_reg <= `LED_OUT_RESET;
      fault_pin_reg <= 1'b0;
    end
    else
    begin
      status_led_reg <= config_reg.status_led_sw_ctrl
                      ? led_reg[`STATUS_LED_MSB:`STATUS_LED_LSB]
                      : level_sync;
      fault_led_reg <= config_reg.fault_led_sw_ctrl
                     ? led_reg[`FAULT_LED_MSB:`FAULT_LED_LSB]
                     : (demag_reg | supply_reg);
      fault_pin_reg <= (|supply_reg)
                     & ~config_reg.supply_error_mask_bit;
    end
  end

  assign status_led_out = status_led_reg;
  assign fault_led_out = fault_led_reg;
  assign fault_out = fault_pin_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_LED_WRITE:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      wr_led |=> led_reg == $past(apb_req_in.pwdata[7:0]))
    else $error("LED register did not take written byte");

  AST_STATUS_HW:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !config_reg.status_led_sw_ctrl |=> status_led_out == $past(level_sync))
    else $error("Status LEDs not following channel level");

  AST_STATUS_SW:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      config_reg.status_led_sw_ctrl
      |=> status_led_out == $past(led_reg[7:4]))
    else $error("Status LEDs not following software bits");

  AST_FAULT_HW:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !config_reg.fault_led_sw_ctrl
      |=> fault_led_out == ($past(demag_reg) | $past(supply_reg)))
    else $error("Fault LEDs not following fault state");

  AST_FAULT_SW:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      config_reg.fault_led_sw_ctrl |=> fault_led_out == $past(led_reg[3:0]))
    else $error("Fault LEDs not following software bits");

  AST_DEMAG_LATCH:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (|demag_sync) |=> (demag_reg & $past(demag_sync)) == $past(demag_sync))
    else $error("Demag thermal flag not latched");

  AST_LEVEL_VIEW:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      setup_phase && hit_level
      |=> prdata_reg[3:0] == ($past(config_reg.level_or_supply_select)
          ? $past(supply_reg) : $past(level_sync)))
    else $error("Level register low nibble has wrong source");

  AST_SUPPLY_SET:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (|supply_bad) |=> (supply_reg & $past(supply_bad)) == $past(supply_bad))
    else $error("Supply fault not set on bad supply");

  AST_SUPPLY_HOLD:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !rd_level |=> (supply_reg & $past(supply_reg)) == $past(supply_reg))
    else $error("Supply fault dropped without a read");

  AST_GLOBAL_ERR:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (|supply_reg) && !config_reg.supply_summary_disable
      |=> global_supply_error_out)
    else $error("Global supply error not raised");

  AST_FAULT_PIN:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      ##1 fault_out == ((|$past(supply_reg))
                        & ~$past(config_reg.supply_error_mask_bit)))
    else $error("Fault output disagrees with supply faults");

  AST_READ_CLEAR:
    assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rd_level && demag_sync == 4'h0
      |=> (demag_reg & $past(snap_reg[7:4])) == 4'h0)
    else $error("Level register read did not clear demag flags");

endmodule

// ==== core/led_level_params.svh ====
`ifndef LED_LEVEL_PARAMS_SVH
`define LED_LEVEL_PARAMS_SVH

// ****************************************************************
// Register indices, byte address is index shifted left by two
// ****************************************************************
`define IDX_LED_CONTROL 8'h01
`define IDX_LEVEL_FAULTS 8'h02
`define IDX_CONFIG 8'h04
`define IDX_IRQ_STATUS 8'h05
`define IDX_IRQ_CLEAR 8'h06
`define IDX_IRQ_ENABLE 8'h07
`define IDX_PIN_STATE 8'h08
`define ADDR_SHIFT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define LED_CONTROL_RESET 8'h00
`define LEVEL_FAULTS_RESET 4'h0
`define CONFIG_RESET 6'h00
`define IRQ_RESET 2'h0
`define LED_OUT_RESET 4'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define STATUS_LED_MSB 7
`define STATUS_LED_LSB 4
`define FAULT_LED_MSB 3
`define FAULT_LED_LSB 0
`define CONFIG_MSB 5
`define IRQ_SUPPLY_BIT 0
`define IRQ_DEMAG_BIT 1
`define IRQ_MSB 1
`define CHANNEL_COUNT 4

`endif

// ==== core/led_level_pkg.sv ====
package led_level_pkg;

  // APB request as seen by the slave
  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer
  typedef struct packed
  {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // Configuration bits, status_led_sw_ctrl at bit 0
  typedef struct packed
  {
    logic supply_error_mask_bit;
    logic supply_summary_disable;
    logic supply_on_threshold_sel;
    logic level_or_supply_select;
    logic fault_led_sw_ctrl;
    logic status_led_sw_ctrl;
  } config_t;

  // Per-channel pin inputs, channel one in bit 0
  typedef struct packed
  {
    logic [3:0] supply_ok_high;
    logic [3:0] supply_ok_low;
    logic [3:0] demag_thermal;
    logic [3:0] io_channel_pin;
  } channel_pins_t;

endpackage

// ==== core/sync_2ff.sv ====
`timescale 1ns/1ps
module sync_2ff
#(
  parameter int WIDTH = 16
)
(
  input logic clk_in,
  input logic arst_n_in,
  input logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  // First stage is read by the second stage only
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("sync_2ff width must be positive");
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_reg <= '0;
      stable_reg <= '0;
    end
    else
    begin
      meta_reg <= d_in;
      stable_reg <= meta_reg;
    end
  end

  assign q_out = stable_reg;

endmodule

// ==== dv/led_level_regs_tb.sv ====
`timescale 1ns/1ps
`include "led_level_params.svh"

module led_level_regs_tb;

  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  localparam logic [7:0] A_LED = (`IDX_LED_CONTROL << `ADDR_SHIFT);
  localparam logic [7:0] A_LVL = (`IDX_LEVEL_FAULTS << `ADDR_SHIFT);
  localparam logic [7:0] A_CFG = (`IDX_CONFIG << `ADDR_SHIFT);
  localparam logic [7:0] A_STAT = (`IDX_IRQ_STATUS << `ADDR_SHIFT);
  localparam logic [7:0] A_CLR = (`IDX_IRQ_CLEAR << `ADDR_SHIFT);
  localparam logic [7:0] A_EN = (`IDX_IRQ_ENABLE << `ADDR_SHIFT);
  localparam logic [7:0] A_PINS = (`IDX_PIN_STATE << `ADDR_SHIFT);

  logic clk_in;
  logic arst_n_in;
  led_level_pkg::apb_req_t apb_req;
  led_level_pkg::apb_rsp_t apb_rsp;
  led_level_pkg::channel_pins_t pins;
  led_level_pkg::channel_pins_t pins_idle;
  logic [3:0] status_led_out;
  logic [3:0] fault_led_out;
  logic fault_out;
  logic global_supply_error_out;
  logic irq_out;
  int fails;
  int n_checks;
  int cycle_count;
  logic [31:0] rdata;
  logic rerr;

  led_level_regs i_led_level_regs
  (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .apb_req_in(apb_req),
    .apb_rsp_out(apb_rsp),
    .pins_in(pins),
    .status_led_out(status_led_out),
    .fault_led_out(fault_led_out),
    .fault_out(fault_out),
    .global_supply_error_out(global_supply_error_out),
    .irq_out(irq_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic stop_test();
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held from setup until the edge that sees pready high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk_in);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
      fails++;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d}, rdata, rerr);
    check(rerr, 1'b0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rdata, rerr);
    check(rerr, 1'b0);
    check(rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Short fault pulse; long enough to cross the synchroniser
  task automatic pulse(input led_level_pkg::channel_pins_t p);
    @(posedge clk_in);
    pins <= p;
    idle(4);
    pins <= pins_idle;
    idle(6);
  endtask

  always @(posedge clk_in)
  begin
    cycle_count++;
    if (cycle_count == 5000)
    begin
      fails++;
      stop_test();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    fails = 0;
    n_checks = 0;
    cycle_count = 0;
    arst_n_in = 1'b0;
    apb_req = '0;
    pins_idle = '{4'hf, 4'hf, 4'h0, 4'h6};
    pins = '{4'hf, 4'hf, 4'h0, 4'h0};
    idle(5);
    arst_n_in <= 1'b1;
    rd_chk(A_LED, 32'h0);
    rd_chk(A_LVL, 32'h0);
    rd_chk(A_STAT, 32'h0);
    check(fault_out, 1'b0);
    rd_chk(A_PINS, 32'hff);
    // LED register and its two modes
    pins <= pins_idle;
    wr(A_LED, 8'ha5);
    rd_chk(A_LED, 32'ha5);
    idle(6);
    check(status_led_out, 4'h6);
    check(fault_led_out, 4'h0);
    rd_chk(A_LVL, 32'h06);
    wr(A_CFG, 8'h03);
    idle(3);
    check(status_led_out, 4'ha);
    check(fault_led_out, 4'h5);
    wr(A_LED, 8'h3c);
    idle(3);
    check(status_led_out, 4'h3);
    check(fault_led_out, 4'hc);
    // Demag latch, masked then enabled interrupt
    wr(A_CFG, 8'h00);
    pulse('{4'hf, 4'hf, 4'h9, 4'h6});
    check(fault_led_out, 4'h9);
    check(irq_out, 1'b0);
    wr(A_EN, 8'h02);
    idle(2);
    check(irq_out, 1'b1);
    rd_chk(A_LVL, 32'h96);
    rd_chk(A_LVL, 32'h06);
    wr(A_CLR, 8'h02);
    idle(2);
    check(irq_out, 1'b0);
    // Supply fault at the low threshold, latched past recovery
    wr(A_CFG, 8'h04);
    wr(A_EN, 8'h01);
    pulse('{4'hf, 4'hd, 4'h0, 4'h6});
    check(global_supply_error_out, 1'b1);
    check(fault_out, 1'b1);
    check(irq_out, 1'b1);
    rd_chk(A_LVL, 32'h02);
    rd_chk(A_LVL, 32'h00);
    wr(A_CLR, 8'h01);
    idle(2);
    check(global_supply_error_out, 1'b0);
    check(irq_out, 1'b0);
    // High threshold picks the other supply-good input
    wr(A_CFG, 8'h0c);
    pulse('{4'h7, 4'hf, 4'h0, 4'h6});
    rd_chk(A_LVL, 32'h08);
    wr(A_CLR, 8'h01);
    // Summary disable and mask keep the flag local
    wr(A_CFG, 8'h34);
    pulse('{4'hf, 4'he, 4'h0, 4'h6});
    check(global_supply_error_out, 1'b0);
    check(fault_out, 1'b0);
    rd_chk(A_LVL, 32'h01);
    // Refused accesses
    xfer(1'b1, A_LVL, 32'hff, rdata, rerr);
    check(rerr, 1'b1);
    rd_chk(A_LVL, 32'h00);
    xfer(1'b0, 8'h3c, 32'h0, rdata, rerr);
    check(rerr, 1'b1);
    check(rdata, 32'h0);
    stop_test();
  end

endmodule
